// file: include/sync_proc_consts.vh
// Register indexes, field positions, reset values and timing counts for sync processing
`ifndef SYNC_PROC_CONSTS_VH
`define SYNC_PROC_CONSTS_VH
// ----------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------
`define IDX_SEP_THR 6'h11
`define IDX_HS_POL 6'h12
`define IDX_VS_CTRL 6'h14
`define IDX_PRECOAST 6'h16
`define IDX_POSTCOAST 6'h17
`define IDX_COAST_CTRL 6'h18
`define IDX_SLICER 6'h1D
`define IDX_HS_SEL 6'h20
`define IDX_WINDOW 6'h23
`define IDX_STATUS 6'h25
`define IDX_COUNT_LO 6'h26
`define IDX_COUNT_HI 6'h27
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_SEP_THR 8'h20
`define RST_HS_POL 8'h10
`define RST_VS_CTRL 8'h04
`define RST_PRECOAST 8'h02
`define RST_POSTCOAST 8'h0A
`define RST_COAST_CTRL 8'h20
`define RST_SLICER 8'h80
`define RST_HS_SEL 8'h06
`define RST_WINDOW 8'h0A
// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define HS_POL_MSB 5
`define HS_POL_LSB 4
`define VS_FILT_EN_BIT 2
`define VS_SRC_MSB 7
`define VS_SRC_LSB 6
`define COAST_POL_MSB 6
`define COAST_POL_LSB 5
`define COAST_EXT_BIT 7
`define SLICER_MSB 7
`define SLICER_LSB 3
`define HS_SEL_PLL_FILT_BIT 2
`define HS_SEL_REGEN_BIT 1
`define HS_SEL_CSYNC_SOG_BIT 0
`define ST_EXTRA_BIT 1
`define ST_FIELD_BIT 0
`define POL_ACTIVE_HIGH 2'h1
`define VS_SRC_SEPARATED 2'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define SEP_UNIT_NS 200
`define FINE_UNIT_NS 25
`define SEP_UNIT_CYC ((`SEP_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FINE_UNIT_CYC ((`FINE_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REGENERATED_HSYNC_OUT_CYC 8'h20
`define EXTRA_LINES 8'h40
`endif

// file: verilog/unit_tick.v
// Time-unit prescaler: one-cycle tick every CYCLES clocks while run is high
`timescale 1ns/1ps
module unit_tick #(
  parameter CYCLES = 20,
  parameter W = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire run,
  output reg tick
);
  localparam [W-1:0] LAST = CYCLES - 1;
  reg [W-1:0] cnt;
  // Restarting on run low keeps the unit phase-locked to the pulse start
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= {W{1'b0}};
      tick <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt <= {W{1'b0}};
        tick <= 1'b0;
      end else if (cnt == LAST) begin
        cnt <= {W{1'b0}};
        tick <= 1'b1;
      end else begin
        cnt <= cnt + 1'b1;
        tick <= 1'b0;
      end
    end
  end
endmodule

// file: verilog/duration_gate.v
// Pulse-width gate: passes a level only after it has lasted limit ticks
`timescale 1ns/1ps
module duration_gate #(
  parameter W = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire level,
  input wire tick,
  input wire [W-1:0] limit,
  output reg pass
);
  reg [W-1:0] cnt;
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= {W{1'b0}};
      pass <= 1'b0;
    end else if (ce) begin
      if (!level) begin
        cnt <= {W{1'b0}};
        pass <= 1'b0;
      end else begin
        if (tick && cnt != {W{1'b1}})
          cnt <= cnt + 1'b1;
        pass <= (cnt >= limit);
      end
    end
  end
endmodule

// file: verilog/sync_processor.v
// Sync processing: slicer, separator, hsync regenerator and filter, vsync filter, coast
//
// How it works
// - Green level below a five-bit threshold gives digital composite sync.
// - Composite sync comes from sliced green or from the hsync input.
// - Composite pulses shorter than the threshold are dropped; long ones pass as vsync.
// - Separator threshold is the programmed N times 200 ns.
// - Extracted vsync lags the original edge by N times the unit.
// - Regenerator needs no setup and rides over extra and missing pulses.
// - Regenerated hsync feeds mode detection and counting, never the PLL.
// - Filter window is plus or minus x times 25 ns, rounded up to three clocks (30 ns), around regenerated edge.
// - Sync pulses outside the window are removed from filtered hsync.
// - Status bit shows that extraneous pulses are being seen.
// - Control bit picks filtered or raw sync as PLL reference.
// - Control bit picks regenerated or raw hsync for downstream processing.
// - Vsync filter moves vsync so its edge never meets an hsync edge.
// - One enable bit switches the vsync filter.
// - Vsync filter gives odd/even field from vsync position in the line.
// - Regenerated hsyncs are counted per vsync period.
// - Coast holds the PLL frequency while hsync is absent or disturbed.
// - Internal coast starts pre lines before vsync and ends post lines after.
// - Hsync and coast input polarity fields; value one means active high.
// - Coast select bit zero uses internal coast; a field picks its vsync source.
`timescale 1ns/1ps
`include "sync_proc_consts.vh"
module sync_processor #(
  parameter ADDR_W = 8,
  parameter PW = 16,
  parameter LW = 12
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire awvalid,
  output reg awready,
  input wire [ADDR_W-1:0] awaddr,
  input wire wvalid,
  output reg wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  input wire arvalid,
  output reg arready,
  input wire [ADDR_W-1:0] araddr,
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  input wire [7:0] green_sync_input,
  input wire hsync_in,
  input wire vsync_in,
  input wire coast_in,
  output reg regenerated_hsync_out,
  output reg pll_reference,
  output reg coast_out,
  output reg vsync_out,
  output reg odd_even_field
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] sep_thr;
  reg [7:0] hs_pol;
  reg [7:0] vs_ctrl;
  reg [7:0] precoast;
  reg [7:0] postcoast;
  reg [7:0] coast_ctrl;
  reg [7:0] slicer;
  reg [7:0] hs_sel;
  reg [7:0] window;
  reg [LW-1:0] hs_per_vs;
  reg extra_flag;
  reg aw_full;
  reg w_full;
  reg [5:0] aw_idx;
  reg [7:0] w_byte;
  reg w_lane0;
  reg [7:0] rd_val;
  reg rd_ok;
  reg wr_ok;
  wire [5:0] ar_idx = araddr[7:2];
  wire [15:0] cnt_wide = {{(16-LW){1'b0}}, hs_per_vs};

  always @* begin
    rd_val = 8'h00;
    rd_ok = 1'b1;
    if (ar_idx == `IDX_SEP_THR) begin
      rd_val = sep_thr;
    end else if (ar_idx == `IDX_HS_POL) begin
      rd_val = hs_pol;
    end else if (ar_idx == `IDX_VS_CTRL) begin
      rd_val = vs_ctrl;
    end else if (ar_idx == `IDX_PRECOAST) begin
      rd_val = precoast;
    end else if (ar_idx == `IDX_POSTCOAST) begin
      rd_val = postcoast;
    end else if (ar_idx == `IDX_COAST_CTRL) begin
      rd_val = coast_ctrl;
    end else if (ar_idx == `IDX_SLICER) begin
      rd_val = slicer;
    end else if (ar_idx == `IDX_HS_SEL) begin
      rd_val = hs_sel;
    end else if (ar_idx == `IDX_WINDOW) begin
      rd_val = window;
    end else if (ar_idx == `IDX_STATUS) begin
      rd_val[`ST_EXTRA_BIT] = extra_flag;
      rd_val[`ST_FIELD_BIT] = odd_even_field;
    end else if (ar_idx == `IDX_COUNT_LO) begin
      rd_val = cnt_wide[7:0];
    end else if (ar_idx == `IDX_COUNT_HI) begin
      rd_val = cnt_wide[15:8];
    end else begin
      rd_ok = 1'b0;
    end
  end

  always @* begin
    wr_ok = 1'b1;
    if (aw_idx == `IDX_SEP_THR || aw_idx == `IDX_HS_POL || aw_idx == `IDX_VS_CTRL) begin
      wr_ok = 1'b1;
    end else if (aw_idx == `IDX_PRECOAST || aw_idx == `IDX_POSTCOAST) begin
      wr_ok = 1'b1;
    end else if (aw_idx == `IDX_COAST_CTRL || aw_idx == `IDX_SLICER) begin
      wr_ok = 1'b1;
    end else if (aw_idx == `IDX_HS_SEL || aw_idx == `IDX_WINDOW) begin
      wr_ok = 1'b1;
    end else if (aw_idx == `IDX_STATUS || aw_idx == `IDX_COUNT_LO) begin
      wr_ok = 1'b1;
    end else if (aw_idx == `IDX_COUNT_HI) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  // Address and data are held separately so either may arrive first
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_idx <= 6'h00;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      sep_thr <= `RST_SEP_THR;
      hs_pol <= `RST_HS_POL;
      vs_ctrl <= `RST_VS_CTRL;
      precoast <= `RST_PRECOAST;
      postcoast <= `RST_POSTCOAST;
      coast_ctrl <= `RST_COAST_CTRL;
      slicer <= `RST_SLICER;
      hs_sel <= `RST_HS_SEL;
      window <= `RST_WINDOW;
    end else if (ce) begin
      if (awready && awvalid) begin
        aw_full <= 1'b1;
        awready <= 1'b0;
        aw_idx <= awaddr[7:2];
      end else if (!aw_full && !bvalid) begin
        awready <= 1'b1;
      end
      if (wready && wvalid) begin
        w_full <= 1'b1;
        wready <= 1'b0;
        w_byte <= wdata[7:0];
        w_lane0 <= wstrb[0];
      end else if (!w_full && !bvalid) begin
        wready <= 1'b1;
      end
      if (aw_full && w_full && !bvalid) begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        if (w_lane0) begin
          if (aw_idx == `IDX_SEP_THR) begin
            sep_thr <= w_byte;
          end else if (aw_idx == `IDX_HS_POL) begin
            hs_pol <= w_byte;
          end else if (aw_idx == `IDX_VS_CTRL) begin
            vs_ctrl <= w_byte;
          end else if (aw_idx == `IDX_PRECOAST) begin
            precoast <= w_byte;
          end else if (aw_idx == `IDX_POSTCOAST) begin
            postcoast <= w_byte;
          end else if (aw_idx == `IDX_COAST_CTRL) begin
            coast_ctrl <= w_byte;
          end else if (aw_idx == `IDX_SLICER) begin
            slicer <= w_byte;
          end else if (aw_idx == `IDX_HS_SEL) begin
            hs_sel <= w_byte;
          end else if (aw_idx == `IDX_WINDOW) begin
            window <= w_byte;
          end
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_full <= 1'b0;
        w_full <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else if (ce) begin
      if (arready && arvalid) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= {24'h000000, rd_val};
        rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end else if (!rvalid) begin
        arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Slicer, source select and separator
  // ----------------------------------------
  reg sync_on_green;
  reg csync_d;
  wire hs_act = (hs_pol[`HS_POL_MSB:`HS_POL_LSB] == `POL_ACTIVE_HIGH) ? hsync_in : ~hsync_in;
  wire csync = hs_sel[`HS_SEL_CSYNC_SOG_BIT] ? sync_on_green : hs_act;
  wire raw_rise = csync & ~csync_d;
  wire sep_tick;
  wire sep_vsync;

  always @(posedge aclk) begin
    if (!aresetn) begin
      sync_on_green <= 1'b0;
      csync_d <= 1'b0;
    end else if (ce) begin
      sync_on_green <= (green_sync_input < {slicer[`SLICER_MSB:`SLICER_LSB], 3'h0});
      csync_d <= csync;
    end
  end

  // 200 ns unit restarts at each pulse start
  unit_tick #(.CYCLES(`SEP_UNIT_CYC), .W(8)) sep_unit (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .run(csync),
    .tick(sep_tick)
  );

  // Output rises N units after the pulse start, so short pulses never pass
  duration_gate #(.W(8)) separator (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .level(csync),
    .tick(sep_tick),
    .limit(sep_thr),
    .pass(sep_vsync)
  );

  // ----------------------------------------
  // Hsync regenerator and filter
  // ----------------------------------------
  reg [PW-1:0] cnt;
  reg [PW-1:0] period;
  reg seen;
  reg locked;
  reg [2:0] misses;
  reg regen_edge;
  reg filt_hs;
  reg [7:0] extra_age;
  reg [7:0] hs_stretch;
  wire [31:0] hw_wide = window * `FINE_UNIT_CYC;
  wire [PW-1:0] hw = hw_wide[PW-1:0];
  wire [PW:0] late = {1'b0, period} + {4'h0, period[PW-1:3]};
  wire early = cnt < (period - {2'h0, period[PW-1:2]});
  wire in_win = locked && (cnt <= hw || ({1'b0, cnt} + {1'b0, hw}) >= {1'b0, period});
  wire miss = locked && ({1'b0, cnt} == late);
  wire [PW:0] near_lo = {1'b0, period} - {4'h0, period[PW-1:3]};
  wire period_match = ({1'b0, cnt} >= near_lo) && ({1'b0, cnt} <= late);
  wire take_rise = raw_rise && !(locked && early);

  // Early edges are ignored and a missing edge is replaced by a flywheel edge
  // Lock waits for two matching periods, so an idle gap is never taken for a line
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= {PW{1'b0}};
      period <= {PW{1'b0}};
      seen <= 1'b0;
      locked <= 1'b0;
      misses <= 3'h0;
      regen_edge <= 1'b0;
    end else if (ce) begin
      regen_edge <= 1'b0;
      if (take_rise) begin
        regen_edge <= 1'b1;
        cnt <= {PW{1'b0}};
        seen <= 1'b1;
        misses <= 3'h0;
        if (seen) begin
          period <= cnt;
          if (period_match)
            locked <= 1'b1;
        end
      end else if (miss) begin
        regen_edge <= 1'b1;
        cnt <= {3'h0, period[PW-1:3]};
        misses <= misses + 1'b1;
        if (misses == 3'h7)
          locked <= 1'b0;
      end else if (cnt == {PW{1'b1}}) begin
        locked <= 1'b0;
        seen <= 1'b0;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      filt_hs <= 1'b0;
      extra_age <= 8'hFF;
      extra_flag <= 1'b0;
      hs_stretch <= 8'h00;
      regenerated_hsync_out <= 1'b0;
      pll_reference <= 1'b0;
    end else if (ce) begin
      if (!csync)
        filt_hs <= 1'b0;
      else if (raw_rise && in_win)
        filt_hs <= 1'b1;
      // Fresh detection wins over ageing on the same cycle
      if (raw_rise && locked && !in_win)
        extra_age <= 8'h00;
      else if (regen_edge && extra_age != 8'hFF)
        extra_age <= extra_age + 1'b1;
      extra_flag <= (extra_age < `EXTRA_LINES);
      if (regen_edge)
        hs_stretch <= `REGENERATED_HSYNC_OUT_CYC;
      else if (hs_stretch != 8'h00)
        hs_stretch <= hs_stretch - 1'b1;
      regenerated_hsync_out <= regen_edge || (hs_stretch > 8'h01);
      // Regenerated edge is jittery, so it is never a PLL choice
      pll_reference <= hs_sel[`HS_SEL_PLL_FILT_BIT] ? filt_hs : csync;
    end
  end

  // ----------------------------------------
  // Vsync filter, line count and coast
  // ----------------------------------------
  reg vs_raw_d;
  reg vs_f_d;
  reg pend_field;
  reg [LW-1:0] hcount;
  wire [1:0] vs_src = vs_ctrl[`VS_SRC_MSB:`VS_SRC_LSB];
  wire vs_raw = (vs_src == `VS_SRC_SEPARATED) ? sep_vsync : vsync_in;
  wire filt_en = vs_ctrl[`VS_FILT_EN_BIT];
  wire mid_line = locked && (cnt == {1'b0, period[PW-1:1]});
  wire proc_edge = hs_sel[`HS_SEL_REGEN_BIT] ? regen_edge : raw_rise;
  wire vs_rise = vsync_out & ~vs_f_d;
  wire coast_ext = (coast_ctrl[`COAST_POL_MSB:`COAST_POL_LSB] == `POL_ACTIVE_HIGH) ?
                   coast_in : ~coast_in;
  wire pre_hit = ({1'b0, hcount} + {5'h00, precoast}) >= {1'b0, hs_per_vs};
  wire int_coast = (hs_per_vs != {LW{1'b0}}) &&
                   (pre_hit || hcount < {4'h0, postcoast});

  // Filtered vsync moves only at mid-line, away from any hsync edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      vs_raw_d <= 1'b0;
      vs_f_d <= 1'b0;
      pend_field <= 1'b0;
      vsync_out <= 1'b0;
      odd_even_field <= 1'b0;
    end else if (ce) begin
      vs_raw_d <= vs_raw;
      vs_f_d <= vsync_out;
      if (vs_raw && !vs_raw_d)
        // A vsync edge on the line's own hsync edge belongs to the first half
        pend_field <= !take_rise && (cnt >= {1'b0, period[PW-1:1]});
      if (!filt_en)
        vsync_out <= vs_raw;
      else if (mid_line)
        vsync_out <= vs_raw;
      if (filt_en && vs_rise)
        odd_even_field <= pend_field;
    end
  end

  // Software must have the vsync filter on for a trustworthy count
  always @(posedge aclk) begin
    if (!aresetn) begin
      hcount <= {LW{1'b0}};
      hs_per_vs <= {LW{1'b0}};
      coast_out <= 1'b0;
    end else if (ce) begin
      if (vs_rise) begin
        hs_per_vs <= hcount;
        hcount <= {LW{1'b0}};
      end else if (proc_edge && hcount != {LW{1'b1}}) begin
        hcount <= hcount + 1'b1;
      end
      coast_out <= coast_ctrl[`COAST_EXT_BIT] ? coast_ext : int_coast;
    end
  end
endmodule

// file: tb/sync_processor_props.sv
// Port checker for the sync processor, bound to every instance
`timescale 1ns/1ps
module sync_processor_props (
  input wire aclk,
  input wire aresetn,
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire bvalid,
  input wire bready,
  input wire [1:0] bresp,
  input wire arvalid,
  input wire arready,
  input wire rvalid,
  input wire rready,
  input wire [31:0] rdata,
  input wire regenerated_hsync_out,
  input wire vsync_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] hi_len;
  // Length of the current regenerated pulse, in cycles
  always @(posedge aclk) begin
    if (!aresetn)
      hi_len <= 8'h00;
    else if (regenerated_hsync_out)
      hi_len <= hi_len + 8'h01;
    else
      hi_len <= 8'h00;
  end
  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence b_done;
    bvalid && bready;
  endsequence
  sequence slot_back;
    !bvalid && !awready ##1 awready && wready;
  endsequence
  pulse_width_a: assert property (
    $fell(regenerated_hsync_out) |-> hi_len == 8'h20) else $error("regen pulse width wrong");
  edges_apart_a: assert property (
    $rose(vsync_out) |-> !$rose(regenerated_hsync_out)) else $error("vsync and hsync edges meet");
  wr_answer_a: assert property (
    wr_take |=> !bvalid ##1 bvalid) else $error("write response late");
  wr_close_a: assert property (
    b_done |=> slot_back) else $error("write slot not reopened");
  bresp_hold_a: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped");
  rd_answer_a: assert property (
    arvalid && arready |=> rvalid) else $error("read data late");
  rdata_hold_a: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped");
  rd_close_a: assert property (
    rvalid && rready |=> !rvalid) else $error("read data held too long");
  rdata_width_a: assert property (
    rvalid |-> rdata[31:8] == 24'h0) else $error("read data upper bits set");
endmodule
bind sync_processor sync_processor_props props_inst (.aclk, .aresetn, .awvalid, .awready,
  .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
  .regenerated_hsync_out, .vsync_out);

// file: tb/sync_source.sv
// Video source model: hsync and vsync trains with optional faults
`timescale 1ns/1ps
module sync_source #(
  parameter int P = 100,
  parameter int LINES = 30,
  parameter int VW = 3
) (
  input wire logic aclk,
  input wire logic run,
  input wire logic extra,
  input wire logic skip,
  input wire logic half,
  output logic hsync,
  output logic vsync,
  output int line,
  output int pix
);
  // Lines idle low between runs; half moves vsync to three quarters of a line
  always @(posedge aclk) begin
    if (!run) begin
      pix <= 0;
      line <= 0;
      hsync <= 1'h0;
      vsync <= 1'h0;
    end else begin
      pix <= (pix == P - 1) ? 0 : pix + 1;
      if (pix == P - 1)
        line <= (line == LINES - 1) ? 0 : line + 1;
      hsync <= (pix < 8 && !(skip && line == 15)) || (extra && pix >= P / 2 && pix < P / 2 + 4);
      vsync <= half ? ((line == 0 && pix >= 3 * P / 4) || (line > 0 && line < VW) ||
        (line == VW && pix < 3 * P / 4)) : (line < VW);
    end
  end
endmodule

// file: tb/tb.sv
// Self-checking bench for the sync processor
`timescale 1ns/1ps
`include "sync_proc_consts.vh"
module tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, man_h, src_h, src_v, coast_in, reg_hs, pll_ref, coast_out;
  logic vsync_out, field, run, extra, skip, half, v_d, r_d, p_d;
  logic [7:0] awaddr, araddr, green, rd;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  int line, pix, n_errors, checks_done, n_vs, n_reg, n_pll, t;
  logic [23:0] rows [9] = '{24'h112005, 24'h121030, 24'h140444, 24'h160205, 24'h170A03,
    24'h182040, 24'h1D80A8, 24'h200601, 24'h230A0F};
  sync_processor sync_processor_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'h1),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .green_sync_input(green), .hsync_in(src_h | man_h),
    .vsync_in(src_v), .coast_in(coast_in), .regenerated_hsync_out(reg_hs),
    .pll_reference(pll_ref), .coast_out(coast_out), .vsync_out(vsync_out),
    .odd_even_field(field));
  sync_source sync_source_inst (.aclk(aclk), .run(run), .extra(extra), .skip(skip),
    .half(half), .hsync(src_h), .vsync(src_v), .line(line), .pix(pix));
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    v_d <= vsync_out;
    r_d <= reg_hs;
    p_d <= pll_ref;
    if (vsync_out && !v_d) n_vs++;
    if (reg_hs && !r_d) n_reg++;
    if (pll_ref && !p_d) n_pll++;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    if (n_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Write and read hold each channel until its own ready
  // Answers are accepted one edge late, so a stalled answer is seen held
  task wr(input logic [5:0] i, input logic [7:0] d, input logic [3:0] s);
    logic a, w;
    a = 1'h0;
    w = 1'h0;
    @(posedge aclk);
    awvalid <= 1'h1; awaddr <= {i, 2'h0}; wvalid <= 1'h1;
    wdata <= {24'h0, d}; wstrb <= s;
    while (!(a && w)) begin
      @(posedge aclk);
      if (!a && awready) begin a = 1'h1; awvalid <= 1'h0; end
      if (!w && wready) begin w = 1'h1; wvalid <= 1'h0; end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'h1;
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
    bready <= 1'h0;
  endtask
  task rd_reg(input logic [5:0] i);
    @(posedge aclk);
    arvalid <= 1'h1; araddr <= {i, 2'h0};
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'h1;
    do @(posedge aclk); while (!rvalid);
    rd = rdata[7:0];
    resp = rresp;
    rready <= 1'h0;
  endtask
  task wait_at(input int l);
    do @(posedge aclk); while (!(line == l && pix == 50));
    #1;
  endtask
  task lvl(input int m, input logic v);
    if (m) green <= v ? 8'h00 : 8'hFF;
    else man_h <= v;
  endtask
  initial begin
    repeat (60000) @(posedge aclk);
    n_errors++;
    finish_test;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, man_h, coast_in} = 8'h00;
    {run, extra, skip, half} = 4'h0;
    {awaddr, araddr, wdata, wstrb, green} = {16'h0, 32'h0, 4'h0, 8'hFF};
    repeat (10) @(posedge aclk);
    #1;
    chk({reg_hs, pll_ref, coast_out, vsync_out, field, awready, bvalid, rvalid}, 0);
    @(posedge aclk);
    aresetn <= 1'h1;
    foreach (rows[k]) begin
      rd_reg(rows[k][21:16]); chk(rd, rows[k][15:8]);
      wr(rows[k][21:16], rows[k][7:0], 4'h1); chk(resp, `RESP_OKAY);
      rd_reg(rows[k][21:16]); chk(rd, rows[k][7:0]);
      wr(rows[k][21:16], rows[k][15:8], 4'h1);
    end
    // ----------------------------------------
    // Refused and read-only accesses
    // ----------------------------------------
    wr(6'h3F, 8'h55, 4'h1); chk(resp, `RESP_SLVERR);
    rd_reg(6'h3F); chk({rd, resp}, {8'h00, `RESP_SLVERR});
    wr(`IDX_SEP_THR, 8'h77, 4'h0); rd_reg(`IDX_SEP_THR); chk(rd, `RST_SEP_THR);
    wr(`IDX_STATUS, 8'hFF, 4'h1); chk(resp, `RESP_OKAY);
    rd_reg(`IDX_STATUS); chk(rd, 8'h00);
    // ----------------------------------------
    // Separator from hsync input, then from sliced green
    // ----------------------------------------
    wr(`IDX_SEP_THR, 8'h02, 4'h1);
    wr(`IDX_VS_CTRL, 8'h40, 4'h1);
    for (int m = 0; m < 2; m++) begin
      wr(`IDX_HS_SEL, {7'h03, m[0]}, 4'h1);
      repeat (1000) @(posedge aclk);
      t = n_vs;
      lvl(m, 1'h1);
      repeat (30) @(posedge aclk);
      lvl(m, 1'h0);
      repeat (70) @(posedge aclk);
      chk(n_vs, t);
      lvl(m, 1'h1);
      t = 0;
      while (!vsync_out && t < 100) begin @(posedge aclk); t++; end
      chk(t >= 40 && t <= 45, 1);
      repeat (20) @(posedge aclk);
      lvl(m, 1'h0);
    end
    // ----------------------------------------
    // Framed video with the vsync filter on
    // ----------------------------------------
    wr(`IDX_SEP_THR, `RST_SEP_THR, 4'h1);
    wr(`IDX_VS_CTRL, 8'h04, 4'h1);
    wr(`IDX_HS_SEL, 8'h06, 4'h1);
    run <= 1'h1;
    repeat (9000) @(posedge aclk);
    rd_reg(`IDX_COUNT_LO); chk(rd, 8'h1E);
    rd_reg(`IDX_COUNT_HI); chk(rd, 8'h00);
    rd_reg(`IDX_STATUS); chk(rd[1], 0);
    chk(field, 0);
    wait_at(5); chk(coast_out, 1);
    wait_at(15); chk(coast_out, 0);
    wait_at(29); chk(coast_out, 1);
    half <= 1'h1;
    repeat (6000) @(posedge aclk);
    chk(field, 1);
    half <= 1'h0;
    for (int k = 0; k < 3; k++) begin
      wr(`IDX_HS_SEL, k == 1 ? 8'h02 : 8'h06, 4'h1);
      extra <= k < 2;
      skip <= k == 2;
      wait_at(12);
      n_reg = 0;
      n_pll = 0;
      wait_at(22);
      chk(n_reg >= 9 && n_reg <= 11, 1);
      chk(n_pll >= (k == 1 ? 19 : 9) && n_pll <= (k == 1 ? 21 : 11), 1);
      if (k == 0) begin
        rd_reg(`IDX_STATUS); chk(rd[1], 1);
      end
    end
    extra <= 1'h0;
    skip <= 1'h0;
    // External coast in both polarities
    for (int k = 0; k < 4; k++) begin
      wr(`IDX_COAST_CTRL, k < 2 ? 8'hA0 : 8'hC0, 4'h1);
      coast_in <= (k == 0 || k == 3);
      repeat (5) @(posedge aclk);
      #1;
      chk(coast_out, !k[0]);
    end
    finish_test;
  end
endmodule
